// ### rtl/rras_pkg.sv
// Constants for the remote address remap slot bank
package rras_pkg;
    localparam int NUM_PORTS = 4;
    localparam int NUM_SLOTS = 5;
    localparam int PORT_W = 2;
    localparam int SLOT_W = 3;
    localparam int ADDR7_W = 7;
    localparam int PHYS_MSB = 7;
    localparam int PHYS_LSB = 1;
    localparam logic [7:0] ADDR_PORT_SEL = 8'h4c;
    localparam logic [7:0] ADDR_REMOTE_DEV_1 = 8'h5e;
    localparam logic [7:0] ADDR_REMOTE_DEV_2 = 8'h5f;
    localparam logic [7:0] ADDR_REMOTE_DEV_3 = 8'h60;
    localparam logic [7:0] ADDR_REMOTE_DEV_4 = 8'h61;
    localparam logic [7:0] ADDR_REMOTE_DEV_5 = 8'h62;
    localparam logic [7:0] SLOT_OFFS [NUM_SLOTS] = '{ADDR_REMOTE_DEV_1, ADDR_REMOTE_DEV_2,
        ADDR_REMOTE_DEV_3, ADDR_REMOTE_DEV_4, ADDR_REMOTE_DEV_5};
    localparam logic [7:0] SLOT_RESET = 8'h00;
    localparam logic [PORT_W-1:0] PORT_SEL_RESET = 2'h0;
    localparam logic [ADDR7_W-1:0] ALIAS_OFF = 7'h00;
    typedef logic [NUM_SLOTS*ADDR7_W-1:0] rras_slots_t;
endpackage : rras_pkg

// ### rtl/rras_slot_bank.sv
// One receive port's set of remote physical address slots
`timescale 1ns/1ns
module rras_slot_bank
    import rras_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [rras_pkg::SLOT_W-1:0] wr_idx,
    input wire logic [rras_pkg::ADDR7_W-1:0] wr_data,
    output rras_pkg::rras_slots_t slots
);
    import rras_pkg::*;

    rras_slots_t slots_reg;
    rras_slots_t slots_next;

    // Next slot contents: only the addressed slot changes
    always_comb
    begin
        slots_next = slots_reg;
        for (int i = 0; i < NUM_SLOTS; i++)
        begin
            if (wr_en && (wr_idx == SLOT_W'(i)))
            begin
                slots_next[i*ADDR7_W +: ADDR7_W] = wr_data;
            end
        end
    end

    // Slot storage, cleared by reset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            slots_reg <= {NUM_SLOTS{SLOT_RESET[PHYS_MSB:PHYS_LSB]}};
        end
        else
        begin
            slots_reg <= slots_next;
        end
    end

    assign slots = slots_reg;
endmodule : rras_slot_bank

// ### rtl/rras_remap.sv
// Per-port remote address slots with register access and alias remapping
//
// Operation
// - Bits 7:1 hold writable remote physical address
// - Alias hit forwards stored physical address instead
// - Alias index n uses slot index n
// - Separate copy per port, chosen by 0x4C for register access and by req_port for lookups
// - All slots read zero after reset
// - Zero alias never triggers a remap
`timescale 1ns/1ns
module rras_remap
    import rras_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic req_valid,
    input wire logic [rras_pkg::PORT_W-1:0] req_port,
    input wire logic [rras_pkg::ADDR7_W-1:0] req_addr,
    input wire rras_pkg::rras_slots_t local_alias_match,
    output logic fwd_valid,
    output logic fwd_hit,
    output logic [rras_pkg::SLOT_W-1:0] fwd_slot,
    output logic [rras_pkg::ADDR7_W-1:0] fwd_addr
);
    import rras_pkg::*;

    // Maps a register address to {hit, slot index}
    function automatic logic [SLOT_W:0] slot_decode(input logic [7:0] addr);
        logic [SLOT_W:0] res;
        res = '0;
        for (int i = 0; i < NUM_SLOTS; i++)
        begin
            if (addr == SLOT_OFFS[i])
            begin
                res = {1'b1, SLOT_W'(i)};
            end
        end
        return res;
    endfunction : slot_decode

    rras_slots_t slot_flat [NUM_PORTS];
    logic [PORT_W-1:0] port_sel_reg;
    logic [PORT_W-1:0] port_sel_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic fwd_valid_reg;
    logic fwd_valid_next;
    logic fwd_hit_reg;
    logic fwd_hit_next;
    logic [SLOT_W-1:0] fwd_slot_reg;
    logic [SLOT_W-1:0] fwd_slot_next;
    logic [ADDR7_W-1:0] fwd_addr_reg;
    logic [ADDR7_W-1:0] fwd_addr_next;
    logic [SLOT_W:0] wr_dec;
    logic [SLOT_W:0] rd_dec;
    logic slot_wr;

    assign wr_dec = slot_decode(reg_addr);
    assign rd_dec = slot_decode(reg_addr);
    assign slot_wr = reg_wr && wr_dec[SLOT_W];

    // One slot bank per receive port; only the selected one takes writes
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        rras_slot_bank u_bank (
            .clk(clk),
            .srst(srst),
            .wr_en(slot_wr && (port_sel_reg == PORT_W'(p))),
            .wr_idx(wr_dec[SLOT_W-1:0]),
            .wr_data(reg_wdata[PHYS_MSB:PHYS_LSB]),
            .slots(slot_flat[p])
        );
    end

    // Register read, port select write and remap lookup
    always_comb
    begin
        logic [ADDR7_W-1:0] al;
        al = '0;
        port_sel_next = port_sel_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        fwd_valid_next = req_valid;
        fwd_hit_next = 1'b0;
        fwd_slot_next = '0;
        fwd_addr_next = '0;
        if (reg_wr && (reg_addr == ADDR_PORT_SEL))
        begin
            port_sel_next = reg_wdata[PORT_W-1:0];
        end
        if (reg_rd)
        begin
            rvalid_next = 1'b1;
            rdata_next = 8'h00;
            if (reg_addr == ADDR_PORT_SEL)
            begin
                rdata_next = {{(8-PORT_W){1'b0}}, port_sel_reg};
            end
            else if (rd_dec[SLOT_W])
            begin
                // Read the selected port's copy, bit 0 forced low
                rdata_next = {slot_flat[port_sel_reg][rd_dec[SLOT_W-1:0]*ADDR7_W +: ADDR7_W],
                    1'b0};
            end
        end
        // Descending scan so the lowest matching slot wins
        if (req_valid)
        begin
            for (int i = NUM_SLOTS - 1; i >= 0; i--)
            begin
                al = local_alias_match[i*ADDR7_W +: ADDR7_W];
                if ((al != ALIAS_OFF) && (al == req_addr))
                begin
                    fwd_hit_next = 1'b1;
                    fwd_slot_next = SLOT_W'(i);
                    fwd_addr_next = slot_flat[req_port][i*ADDR7_W +: ADDR7_W];
                end
            end
        end
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            port_sel_reg <= PORT_SEL_RESET;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            fwd_valid_reg <= 1'b0;
            fwd_hit_reg <= 1'b0;
            fwd_slot_reg <= '0;
            fwd_addr_reg <= '0;
        end
        else
        begin
            port_sel_reg <= port_sel_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            fwd_valid_reg <= fwd_valid_next;
            fwd_hit_reg <= fwd_hit_next;
            fwd_slot_reg <= fwd_slot_next;
            fwd_addr_reg <= fwd_addr_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign fwd_valid = fwd_valid_reg;
    assign fwd_hit = fwd_hit_reg;
    assign fwd_slot = fwd_slot_reg;
    assign fwd_addr = fwd_addr_reg;

    // Written slot of the selected port holds bits 7:1 of the data
    AST_SLOT_WRITE: assert property (@(posedge clk) disable iff (srst)
        slot_wr |=> slot_flat[$past(port_sel_reg)][$past(wr_dec[SLOT_W-1:0])*ADDR7_W +: ADDR7_W]
            == $past(reg_wdata[PHYS_MSB:PHYS_LSB]))
        else $error("slot did not store written address");

    // A hit forwards the stored address of the hit slot, indexed as in the lookup cycle
    AST_REMAP_ADDR: assert property (@(posedge clk) disable iff (srst)
        req_valid ##1 fwd_hit |->
            fwd_addr == $past(slot_flat[req_port][fwd_slot_next*ADDR7_W +: ADDR7_W]))
        else $error("forwarded address is not the slot contents");

    // The hit slot is the one whose alias equals the local address
    AST_PAIR_INDEX: assert property (@(posedge clk) disable iff (srst)
        fwd_hit |->
            $past(local_alias_match[fwd_slot_next*ADDR7_W +: ADDR7_W]) == $past(req_addr))
        else $error("hit slot index does not match alias index");

    // A write leaves the next port's copy untouched
    AST_PORT_ISOLATE: assert property (@(posedge clk) disable iff (srst)
        slot_wr |=> slot_flat[PORT_W'($past(port_sel_reg) + 2'h1)] ==
            $past(slot_flat[PORT_W'(port_sel_reg + 2'h1)]))
        else $error("write reached an unselected port");

    // Every slot is zero right after reset
    AST_RESET_ZERO: assert property (@(posedge clk)
        $past(srst) |-> (slot_flat[0] == '0) && (slot_flat[1] == '0) &&
            (slot_flat[2] == '0) && (slot_flat[3] == '0))
        else $error("slot not zero after reset");

    // Slot reads return zero in bit 0
    AST_BIT0_ZERO: assert property (@(posedge clk) disable iff (srst)
        reg_rd && rd_dec[SLOT_W] |=> reg_rvalid && !reg_rdata[0])
        else $error("slot bit 0 read as one");

    // No remap through a zero alias; a request always answers next cycle
    AST_ZERO_ALIAS: assert property (@(posedge clk) disable iff (srst)
        req_valid |=> fwd_valid && (!fwd_hit ||
            $past(local_alias_match[fwd_slot_next*ADDR7_W +: ADDR7_W]) != ALIAS_OFF))
        else $error("remap used a zero alias");
endmodule : rras_remap

// ### sim/rras_ser_model.sv
// Far-side stand-in that records remapped transactions reaching the serializer
`timescale 1ns/1ns
module rras_ser_model
    import rras_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic fwd_valid,
    input wire logic fwd_hit,
    input wire logic [rras_pkg::ADDR7_W-1:0] fwd_addr,
    output logic [7:0] rx_count,
    output logic [rras_pkg::ADDR7_W-1:0] rx_addr
);
    // Only remapped transactions cross the control channel
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rx_count <= 8'h00;
            rx_addr <= 7'h00;
        end
        else if (fwd_valid && fwd_hit)
        begin
            rx_count <= rx_count + 8'h01;
            rx_addr <= fwd_addr;
        end
    end
endmodule : rras_ser_model

// ### sim/rras_remap_bench.sv
// Self-checking bench for the remap slot bank
`timescale 1ns/1ns
module rras_remap_bench;
    import rras_pkg::*;
    logic clk, srst, reg_wr, reg_rd, req_valid, fwd_valid, fwd_hit, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_count;
    logic [PORT_W-1:0] req_port;
    logic [ADDR7_W-1:0] req_addr, fwd_addr, rx_addr;
    logic [SLOT_W-1:0] fwd_slot;
    rras_slots_t alias_v;
    int n_fail = 0;
    int n_compared = 0;
    // Rows: port, slot index, written value, expected readback
    logic [7:0] rows [4][4] = '{'{8'h00, 8'h00, 8'ha5, 8'ha4}, '{8'h01, 8'h02, 8'hff, 8'hfe},
        '{8'h03, 8'h04, 8'h81, 8'h80}, '{8'h02, 8'h01, 8'h3c, 8'h3c}};

    rras_remap u_rras_remap (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .req_valid(req_valid), .req_port(req_port),
        .req_addr(req_addr), .local_alias_match(alias_v), .fwd_valid(fwd_valid),
        .fwd_hit(fwd_hit), .fwd_slot(fwd_slot), .fwd_addr(fwd_addr));
    rras_ser_model u_rras_ser_model (.clk(clk), .srst(srst), .fwd_valid(fwd_valid),
        .fwd_hit(fwd_hit), .fwd_addr(fwd_addr), .rx_count(rx_count), .rx_addr(rx_addr));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Compare one byte-wide result
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Register write, entered and left just after an edge; one idle edge follows
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        @(posedge clk);
        #1;
    endtask : wr

    // Register read; data and valid land one edge later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk("rdata", exp, reg_rdata);
        @(posedge clk);
        #1;
    endtask : rd

    // Lookup request; result stands just after the taking edge
    task automatic lk(input logic [1:0] p, input logic [6:0] a, input logic h,
        input logic [2:0] s, input logic [6:0] pa);
        req_valid = 1'b1;
        req_port = p;
        req_addr = a;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        chk("fwd ctl", {3'h0, 1'b1, h, s}, {3'h0, fwd_valid, fwd_hit, fwd_slot});
        chk("fwd addr", {1'b0, pa}, {1'b0, fwd_addr});
        @(posedge clk);
        #1;
    endtask : lk

    // Counts line, verdict and end of run
    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    // Watchdog against a hung run
    initial
    begin
        #20000;
        n_fail++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        {srst, reg_wr, reg_rd, req_valid} = 4'b1000;
        {reg_addr, reg_wdata, req_port, req_addr, alias_v} = '0;
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        for (int s = 0; s < NUM_SLOTS; s++)
            rd(SLOT_OFFS[s], 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_PORT_SEL, rows[i][0]);
            wr(SLOT_OFFS[rows[i][1]], rows[i][2]);
            rd(SLOT_OFFS[rows[i][1]], rows[i][3]);
        end
        // Port 1 slot 1 untouched by the port 0 write; unmapped place reads zero
        wr(ADDR_PORT_SEL, 8'h01);
        rd(SLOT_OFFS[0], 8'h00);
        rd(8'h70, 8'h00);
        // Slot 5 of port 3 holds 0x40, slot 3 of port 1 holds 0x7f
        alias_v = {7'h33, 7'h00, 7'h11, 14'h0000};
        lk(2'h3, 7'h33, 1'b1, 3'h4, 7'h40);
        lk(2'h1, 7'h11, 1'b1, 3'h2, 7'h7f);
        // Slots 3 and 5 both match; the lower slot wins
        alias_v = {7'h11, 7'h00, 7'h11, 14'h0000};
        lk(2'h1, 7'h11, 1'b1, 3'h2, 7'h7f);
        alias_v = '0;
        lk(2'h0, 7'h00, 1'b0, 3'h0, 7'h00);
        chk("ser count", 8'h03, rx_count);
        chk("ser addr", 8'h7f, {1'b0, rx_addr});
        // Reset in mid-run clears a written slot
        srst = 1'b1;
        @(posedge clk);
        #1;
        srst = 1'b0;
        wr(ADDR_PORT_SEL, 8'h03);
        rd(SLOT_OFFS[4], 8'h00);
        print_verdict();
    end
endmodule : rras_remap_bench
